// ===== design/status_pkg.sv
/*
 package for the serial port status block: register offsets, status bit
 positions, reset values and the event carriers.
 assumes a 32-bit apb register bus with word-aligned registers.
*/
package status_pkg;
    localparam int DATA_W = 32;
    localparam int COUNT_W = 5;
    // register byte offsets
    localparam logic [7:0] STATUS_OFS = 8'h00;
    localparam logic [7:0] CONTROL_OFS = 8'h04;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
    // status field positions
    localparam int RX_COUNT_LSB = 24;
    localparam int TX_COUNT_LSB = 16;
    localparam int FRAME_ERR_BIT = 12;
    localparam int ACTIVITY_BIT = 11;
    localparam int UNDERRUN_BIT = 8;
    localparam int SHIFTER_EMPTY_BIT = 7;
    localparam int OVERFLOW_BIT = 6;
    localparam int RX_EMPTY_BIT = 5;
    localparam int TX_EMPTY_BIT = 3;
    localparam int TX_FULL_BIT = 1;
    localparam int RX_FULL_BIT = 0;
    // control bit positions
    localparam int ENABLE_BIT = 0;
    localparam int ENH_BUF_BIT = 1;
    localparam int FRAMED_BIT = 2;
    localparam int FRAME_EVT_EN_BIT = 3;
    localparam int OVF_EVT_EN_BIT = 4;
    localparam int UR_EVT_EN_BIT = 5;
    // interrupt status/mask layout
    localparam int EVT_W = 3;
    localparam int EVT_FRAME = 0;
    localparam int EVT_OVERFLOW = 1;
    localparam int EVT_UNDERRUN = 2;
    // reset values
    localparam logic [DATA_W-1:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic [EVT_W-1:0] MASK_RESET = 3'h0;

    // state coming from the shifting engine
    typedef struct packed {
        logic [COUNT_W-1:0] rx_count;
        logic [COUNT_W-1:0] tx_count;
        logic busy;
        logic shifter_empty;
        logic rx_ptr_equal;
        logic tx_buf_empty;
        logic tx_buf_full;
        logic rx_buf_full;
        logic frame_error_pulse;
        logic underrun_pulse;
        logic word_received_pulse;
    } engine_state_s;

    // control bits handed to the engine
    typedef struct packed {
        logic enable;
        logic enh_buf;
        logic framed;
    } engine_ctrl_s;
endpackage : status_pkg

// ===== design/sticky_flag.sv
/*
 one sticky status flag: set by hardware, cleared by software or by the
 module being disabled. set wins over clear in the same cycle.
 assumes a single clock and active-low asynchronous reset.
*/
`timescale 1ns/100ps
`default_nettype none
module sticky_flag (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic set_pulse,
    input wire logic clear,
    output logic flag
);
    logic next_flag;

    // set beats clear so an event in the clearing cycle is kept
    always_comb begin
        next_flag = flag;
        if (clear) begin
            next_flag = 1'b0;
        end
        if (set_pulse) begin
            next_flag = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end
endmodule : sticky_flag
`default_nettype wire

// ===== design/serial_port_status.sv
/*
 status register block of a synchronous serial port, with control bits,
 error event flags, mask and a level interrupt, all on an apb slave.
 assumes engine inputs are synchronous to pclk and event inputs are
 one-cycle pulses.
*/
// The implementer's own choices: the APB slave port and the register offsets.
// Notes on behaviour
// RL1 - receive fifo count in bits 28-24
// RL2 - transmit fifo count in bits 20-16
// RL3 - frame error sticky, software clears, framed only
// RL4 - activity bit high while transaction runs
// RL5 - underrun sticky in bit 8, framed only
// RL6 - underrun cleared by re-enable or write zero
// RL7 - shifter empty bit 7, enhanced buffering
// RL8 - overflow when word lands unread; discard it
// RL9 - overflow cleared by re-enable or write zero
// RL10 - rx empty when read and write pointers match
// RL11 - unimplemented status bits read zero
// RL12 - tx empty resets one, others zero; here bits 7 and 5 also read one after reset, from the engine
// RL13 - overflow error event when its enable set
// RL14 - frame error event when its enable set
// RL15 - underrun error event when its enable set
`timescale 1ns/100ps
`default_nettype none
module serial_port_status
    import status_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire engine_state_s engine,
    input wire logic rx_word_unread,
    output engine_ctrl_s ctrl,
    output logic discard_word,
    output logic error_event,
    output logic irq
);
    logic [DATA_W-1:0] control;
    logic [DATA_W-1:0] next_control;
    logic [EVT_W-1:0] irq_mask;
    logic [EVT_W-1:0] next_irq_mask;
    logic [EVT_W-1:0] irq_status;
    logic [EVT_W-1:0] irq_set;
    logic [EVT_W-1:0] irq_clr;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_discard;
    logic next_error_event;
    logic next_irq;
    logic setup;
    logic wr;
    logic frame_flag;
    logic underrun_flag;
    logic overflow_flag;
    logic frame_set;
    logic underrun_set;
    logic overflow_set;
    logic status_zero_wr;
    logic disabling;

    // one wait state: access phase is answered on its first edge
    assign setup = psel && penable && !pready;
    assign wr = setup && pwrite;
    assign disabling = control[ENABLE_BIT] && !next_control[ENABLE_BIT];
    assign status_zero_wr = wr && (paddr == STATUS_OFS);

    // hardware set conditions for the sticky flags
    assign frame_set = engine.frame_error_pulse && control[FRAMED_BIT]; // RL3
    assign underrun_set = engine.underrun_pulse && control[FRAMED_BIT]; // RL5
    assign overflow_set = engine.word_received_pulse && rx_word_unread; // RL8

    // disabling the module or writing zero to the bit clears it
    sticky_flag frame_flag_i (
        .pclk(pclk),
        .presetn(presetn),
        .set_pulse(frame_set),
        .clear(disabling || (status_zero_wr && !pwdata[FRAME_ERR_BIT])), // RL3
        .flag(frame_flag)
    );

    sticky_flag underrun_flag_i (
        .pclk(pclk),
        .presetn(presetn),
        .set_pulse(underrun_set),
        .clear(disabling || (status_zero_wr && !pwdata[UNDERRUN_BIT])), // RL6
        .flag(underrun_flag)
    );

    sticky_flag overflow_flag_i (
        .pclk(pclk),
        .presetn(presetn),
        .set_pulse(overflow_set),
        .clear(disabling || (status_zero_wr && !pwdata[OVERFLOW_BIT])), // RL9
        .flag(overflow_flag)
    );

    // interrupt events are gated by their event enables
    always_comb begin
        irq_set = '0;
        irq_set[EVT_FRAME] = frame_set && control[FRAME_EVT_EN_BIT]; // RL14
        irq_set[EVT_OVERFLOW] = overflow_set && control[OVF_EVT_EN_BIT]; // RL13
        irq_set[EVT_UNDERRUN] = underrun_set && control[UR_EVT_EN_BIT]; // RL15
        irq_clr = '0;
        if (wr && (paddr == IRQ_STATUS_OFS)) begin
            irq_clr = pwdata[EVT_W-1:0];
        end
    end

    // one sticky flag per event, write one to clear
    for (genvar i = 0; i < EVT_W; i++) begin : g_irq
        sticky_flag irq_flag_i (
            .pclk(pclk),
            .presetn(presetn),
            .set_pulse(irq_set[i]),
            .clear(irq_clr[i]),
            .flag(irq_status[i])
        );
    end

    // status word assembly; unlisted bits stay zero
    always_comb begin
        status_word = '0; // RL11
        status_word[RX_COUNT_LSB +: COUNT_W] = engine.rx_count; // RL1
        status_word[TX_COUNT_LSB +: COUNT_W] = engine.tx_count; // RL2
        status_word[FRAME_ERR_BIT] = frame_flag;
        status_word[ACTIVITY_BIT] = engine.busy; // RL4
        status_word[UNDERRUN_BIT] = underrun_flag;
        status_word[SHIFTER_EMPTY_BIT] = engine.shifter_empty; // RL7
        status_word[OVERFLOW_BIT] = overflow_flag;
        status_word[RX_EMPTY_BIT] = engine.rx_ptr_equal; // RL10
        status_word[TX_EMPTY_BIT] = engine.tx_buf_empty; // RL12
        status_word[TX_FULL_BIT] = engine.tx_buf_full;
        status_word[RX_FULL_BIT] = engine.rx_buf_full;
    end

    // register writes and read mux
    always_comb begin
        next_control = control;
        next_irq_mask = irq_mask;
        next_prdata = '0;
        next_pready = setup;
        next_pslverr = 1'b0;
        if (setup) begin
            case (paddr)
                STATUS_OFS: begin
                    next_prdata = status_word;
                end
                CONTROL_OFS: begin
                    next_prdata = control;
                    if (pwrite) begin
                        next_control = {26'h0, pwdata[5:0]};
                    end
                end
                IRQ_STATUS_OFS: begin
                    next_prdata = {29'h0, irq_status};
                end
                IRQ_MASK_OFS: begin
                    next_prdata = {29'h0, irq_mask};
                    if (pwrite) begin
                        next_irq_mask = pwdata[EVT_W-1:0];
                    end
                end
                default: begin
                    next_pslverr = 1'b1; // unmapped address
                end
            endcase
            if (pwrite) begin
                next_prdata = '0;
            end
        end
    end

    // outputs to the engine and the interrupt line
    always_comb begin
        next_discard = overflow_set; // RL8
        next_error_event = |irq_set;
        next_irq = |(irq_status & irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control <= CONTROL_RESET;
            irq_mask <= MASK_RESET;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            discard_word <= 1'b0;
            error_event <= 1'b0;
            irq <= 1'b0;
            ctrl <= '0;
        end else begin
            control <= next_control;
            irq_mask <= next_irq_mask;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            discard_word <= next_discard;
            error_event <= next_error_event;
            irq <= next_irq;
            ctrl.enable <= next_control[ENABLE_BIT];
            ctrl.enh_buf <= next_control[ENH_BUF_BIT];
            ctrl.framed <= next_control[FRAMED_BIT];
        end
    end
endmodule : serial_port_status
`default_nettype wire

// ===== sim/status_sva.sv
/* assertions on the status block ports.
 assumes the fixed one-wait-state apb answer. */
`timescale 1ns/100ps
`default_nettype none
module status_sva
    import status_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pready,
    input wire engine_state_s engine,
    input wire logic rx_word_unread,
    input wire engine_ctrl_s ctrl,
    input wire logic discard_word,
    input wire logic error_event
);
    logic rs;
    logic ovf;
    // remembers that the access ending now targets the status word
    always_ff @(posedge pclk) begin
        rs <= !pwrite && paddr == STATUS_OFS;
    end
    assign ovf = engine.word_received_pulse && rx_word_unread;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_fifo_counts: assert property (pready && rs |->
        prdata[28:24] == $past(engine.rx_count) && prdata[20:16] == $past(engine.tx_count))
        else $error("count field");
    chk_unused_zero: assert property (pready && rs |-> prdata[31:29] == 3'h0 &&
        prdata[23:21] == 3'h0 && prdata[15:13] == 3'h0 && prdata[10:9] == 2'h0
        && prdata[4] == 1'h0 && prdata[2] == 1'h0) else $error("unused bits");
    chk_activity_bit: assert property (pready && rs |->
        prdata[11] == $past(engine.busy)) else $error("activity bit");
    chk_empty_bits: assert property (pready && rs |-> prdata[7] == $past(engine.shifter_empty)
        && prdata[5] == $past(engine.rx_ptr_equal)) else $error("empty bits");
    chk_buffer_bits: assert property (pready && rs |-> prdata[3] == $past(engine.tx_buf_empty)
        && {prdata[1], prdata[0]} == $past({engine.tx_buf_full, engine.rx_buf_full}))
        else $error("buffer bits");
    chk_discard_set: assert property (ovf && ctrl.enable |=> discard_word)
        else $error("no discard");
    chk_discard_cause: assert property (discard_word |-> $past(ovf))
        else $error("stray discard");
    chk_event_cause: assert property (error_event |-> $past(ovf) ||
        $past(ctrl.framed) && $past(engine.frame_error_pulse || engine.underrun_pulse))
        else $error("stray event");
endmodule : status_sva
`default_nettype wire

// ===== sim/engine_model.sv
/* stand-in for the shifting engine: levels and one-cycle event pulses.
 assumes its tasks are called from the pclk domain. */
`timescale 1ns/100ps
`default_nettype none
module engine_model
    import status_pkg::*;
(
    input wire logic pclk,
    output engine_state_s engine,
    output logic rx_word_unread
);
    // idle engine: fifos, shifter and transmit buffer empty
    initial begin
        engine = '0;
        engine.shifter_empty = 1'h1;
        engine.rx_ptr_equal = 1'h1;
        engine.tx_buf_empty = 1'h1;
        rx_word_unread = 1'h0;
    end
    task automatic levels(input logic [4:0] rc, input logic [4:0] tc, input logic b);
        @(posedge pclk);
        engine.rx_count <= rc;
        engine.tx_count <= tc;
        engine.busy <= b;
    endtask : levels
    // k: 0 frame error, 1 word received, 2 underrun; one cycle so no double set
    task automatic fire(input int k, input logic unread);
        @(posedge pclk);
        engine.frame_error_pulse <= k == 0;
        engine.word_received_pulse <= k == 1;
        engine.underrun_pulse <= k == 2;
        rx_word_unread <= unread;
        @(posedge pclk);
        {engine.frame_error_pulse, engine.word_received_pulse, engine.underrun_pulse} <= 3'h0;
    endtask : fire
endmodule : engine_model
`default_nettype wire

// ===== sim/tb.sv
/* self-checking bench: apb accesses against the engine stand-in.
 assumes a 250 MHz pclk and the status package offsets. */
`timescale 1ns/100ps
`default_nettype none
module tb;
    import status_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic rx_word_unread, discard_word, error_event, irq;
    logic [7:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    engine_state_s engine;
    engine_ctrl_s ctrl;
    int errors, checked, events, drops;
    serial_port_status uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .engine(engine), .rx_word_unread(rx_word_unread), .ctrl(ctrl),
        .discard_word(discard_word), .error_event(error_event), .irq(irq));
    engine_model partner (.pclk(pclk), .engine(engine), .rx_word_unread(rx_word_unread));
    initial begin
        pclk = 1'h0;
        forever #2 pclk = ~pclk;
    end
    // pulses are counted as they pass, reads come too late to see them
    always @(posedge pclk) begin
        if (error_event === 1'h1) events++;
        if (discard_word === 1'h1) drops++;
    end
    task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : cmp
    // waits as long as the slave needs; only the watchdog ends a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [DATA_W-1:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask : apb
    task automatic rdx(input logic [7:0] a, input logic [DATA_W-1:0] exp);
        apb(1'h0, a, 32'h0);
        cmp(rd, exp);
    endtask : rdx
    task automatic finish_test();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    // the sequence needs under 2 us
    initial begin
        #20000;
        errors++;
        finish_test();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        rdx(STATUS_OFS, 32'h0000_00a8);
        cmp({29'h0, ctrl}, 32'h0);
        apb(1'h1, CONTROL_OFS, 32'h0000_003f);
        rdx(CONTROL_OFS, 32'h0000_003f);
        cmp({29'h0, ctrl}, 32'h7);
        partner.levels(5'h1f, 5'h10, 1'h1);
        rdx(STATUS_OFS, 32'h1f10_08a8);
        partner.levels(5'h00, 5'h00, 1'h0);
        partner.fire(0, 1'h0);
        rdx(STATUS_OFS, 32'h0000_10a8);
        rdx(IRQ_STATUS_OFS, 32'h0000_0001);
        cmp({31'h0, irq}, 32'h0);
        apb(1'h1, IRQ_MASK_OFS, 32'h0000_0007);
        repeat (2) @(posedge pclk);
        cmp({31'h0, irq}, 32'h1);
        apb(1'h1, IRQ_STATUS_OFS, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        cmp({31'h0, irq}, 32'h0);
        apb(1'h1, STATUS_OFS, 32'h0);
        rdx(STATUS_OFS, 32'h0000_00a8);
        partner.fire(2, 1'h0);
        rdx(STATUS_OFS, 32'h0000_01a8);
        apb(1'h1, CONTROL_OFS, 32'h0000_003e);
        cmp({29'h0, ctrl}, 32'h3);
        apb(1'h1, CONTROL_OFS, 32'h0000_003f);
        rdx(STATUS_OFS, 32'h0000_00a8);
        partner.fire(1, 1'h1);
        rdx(STATUS_OFS, 32'h0000_00e8);
        apb(1'h1, STATUS_OFS, 32'h0);
        partner.fire(1, 1'h0);
        rdx(STATUS_OFS, 32'h0000_00a8);
        // second overflow is cleared by disable and re-enable instead
        partner.fire(1, 1'h1);
        apb(1'h1, CONTROL_OFS, 32'h0000_003e);
        apb(1'h1, CONTROL_OFS, 32'h0000_003f);
        rdx(STATUS_OFS, 32'h0000_00a8);
        partner.fire(1, 1'h0);
        cmp(drops, 2);
        cmp(events, 4);
        apb(1'h1, CONTROL_OFS, 32'h0000_0003);
        cmp({29'h0, ctrl}, 32'h6);
        partner.fire(0, 1'h0);
        partner.fire(2, 1'h0);
        rdx(STATUS_OFS, 32'h0000_00a8);
        apb(1'h1, CONTROL_OFS, 32'h0000_0007);
        cmp({29'h0, ctrl}, 32'h7);
        partner.fire(2, 1'h0);
        rdx(STATUS_OFS, 32'h0000_01a8);
        cmp(events, 4);
        rdx(8'h10, 32'h0);
        cmp({31'h0, err}, 32'h1);
        finish_test();
    end
endmodule : tb
bind serial_port_status status_sva chk (.pclk(pclk), .presetn(presetn), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .engine(engine), .ctrl(ctrl),
    .rx_word_unread(rx_word_unread), .discard_word(discard_word), .error_event(error_event));
`default_nettype wire
